// *** logic/timer_pkg.sv ***
/*
  Shared constants for the prescaled modulo timer: register word offsets,
  control field positions, reset values and the divider table.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package timer_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CNT_HIGH = 8'h04;
  localparam logic [7:0] OFF_CNT_LOW = 8'h08;
  localparam logic [7:0] OFF_LIM_HIGH = 8'h0C;
  localparam logic [7:0] OFF_LIM_LOW = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // Control register field positions
  localparam int DIV_LSB = 0;
  localparam int RESTART_BIT = 4;
  localparam int HALT_BIT = 5;
  localparam int IRQ_EN_BIT = 6;
  localparam int WRAP_FLAG_BIT = 7;
  // Values after reset
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic HALT_RESET = 1'b1;
  localparam logic [7:0] LIMIT_BYTE_RESET = 8'hFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // Divider codes
  localparam logic [2:0] DIV_UNUSED = 3'h7;
  localparam int PRESCALE_WIDTH = 6;
  // Interrupt status bits
  localparam int IRQ_WRAP_BIT = 0;
  localparam int IRQ_WIDTH = 1;
endpackage : timer_pkg

// *** logic/clock_divider.sv ***
/*
  Prescaler: a free-running ripple count whose selected bit edge gives
  a one-cycle tick. Assumes one clock domain and synchronous clear.
*/
`timescale 1ns/1ps
module clock_divider #(
  parameter int WIDTH = timer_pkg::PRESCALE_WIDTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic [2:0] divSelect,
  // Result
  output logic tick
);
  // Codes up to 6 need six stages; fewer would silently lose the slow rates
  if (WIDTH < 6) begin : g_width_check
    $error("clock_divider needs at least six stages");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic tick;
  } state_t;

  state_t cur;
  state_t next_cur;

  // Ones over the low stages that a divider code watches
  function automatic logic [WIDTH-1:0] lowMask(input logic [2:0] code);
    lowMask = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (i < int'(code)) lowMask[i] = 1'b1;
    end
  endfunction : lowMask

  // Code 0 ticks every cycle; code n ticks once per 2**n cycles; 7 never
  always_comb begin
    next_cur = cur;
    next_cur.count = clear ? '0 : cur.count + 1'b1;
    if (clear || divSelect == timer_pkg::DIV_UNUSED) begin
      next_cur.tick = 1'b0;
    end else if (divSelect == 3'h0) begin
      next_cur.tick = 1'b1;
    end else begin
      next_cur.tick = (cur.count & lowMask(divSelect)) == lowMask(divSelect);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;
endmodule : clock_divider

// *** logic/wrap_counter.sv ***
/*
  Sixteen-bit counter that steps on a tick and wraps after the limit.
  Assumes the tick and clear come from the same clock domain.
*/
`timescale 1ns/1ps
module wrap_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic [WIDTH-1:0] limit,
  // Result
  output logic [WIDTH-1:0] count,
  output logic hit
);
  // Register bytes are split at bit 8, so only sixteen bits are served
  if (WIDTH != 16) begin : g_width_check
    $error("wrap_counter is built for sixteen bits");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } state_t;

  state_t cur;
  state_t next_cur;

  // At the limit the next step restarts from zero
  always_comb begin
    next_cur = cur;
    if (clear) begin
      next_cur.count = '0;
    end else if (step) begin
      next_cur.count = (cur.count == limit) ? '0 : cur.count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign count = cur.count;
  assign hit = step && !clear && cur.count == limit;
endmodule : wrap_counter

// *** logic/timer_unit.sv ***
/*
  Prescaled sixteen-bit modulo timer with a Wishbone register slave.
  Assumes a classic Wishbone master on ref_clk, one clock domain.
*/
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module timer_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    logic [2:0] divSelect;
    logic counterHalt;
    logic wrapIrqEnable;
    logic wrapFlag;
    logic restart;
    logic [7:0] limitHigh;
    logic [7:0] limitLow;
    logic [15:0] limitLive;
    logic limitPending;
    logic [7:0] lowHold;
    logic lowHeld;
    logic [timer_pkg::IRQ_WIDTH-1:0] irqStatus;
    logic [timer_pkg::IRQ_WIDTH-1:0] irqMask;
    logic [31:0] dat;
    logic ack;
    logic err;
    logic irq;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic tick;
  logic hit;
  logic [15:0] count;

  // Prescaler follows the divider select and is cleared by restart
  clock_divider #(
    .WIDTH(timer_pkg::PRESCALE_WIDTH)
  ) divider (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(cur.restart),
    .divSelect(cur.divSelect),
    .tick(tick)
  );

  // Counter steps only on enabled prescaler ticks
  wrap_counter #(
    .WIDTH(16)
  ) counter (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(cur.restart),
    .step(tick && !cur.counterHalt),
    .limit(cur.limitLive),
    .count(count),
    .hit(hit)
  );

  // Byte-lane merge for a low byte write
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel,
                                       input logic [31:0] d);
    lane0 = sel[0] ? d[7:0] : old;
  endfunction : lane0

  // Register access, flags and interrupt
  always_comb begin
    logic req;
    logic wr;
    logic rd;
    logic setWrap;
    logic clearWrap;
    req = cyc_i && stb_i && !cur.ack && !cur.err;
    wr = req && we_i;
    rd = req && !we_i;
    setWrap = hit && !cur.limitPending;
    clearWrap = 1'b0;
    next_cur = cur;
    next_cur.ack = 1'b0;
    next_cur.err = 1'b0;
    next_cur.restart = 1'b0;
    next_cur.dat = 32'h00000000;
    if (req) begin
      case (adr_i)
        timer_pkg::OFF_CTRL,
        timer_pkg::OFF_CNT_HIGH,
        timer_pkg::OFF_CNT_LOW,
        timer_pkg::OFF_LIM_HIGH,
        timer_pkg::OFF_LIM_LOW,
        timer_pkg::OFF_IRQ_STATUS,
        timer_pkg::OFF_IRQ_MASK: next_cur.ack = 1'b1;
        default: next_cur.err = 1'b1;
      endcase
    end
    if (wr && sel_i[0]) begin
      case (adr_i)
        timer_pkg::OFF_CTRL: begin
          next_cur.divSelect = dat_i[timer_pkg::DIV_LSB +: 3];
          next_cur.restart = dat_i[timer_pkg::RESTART_BIT];
          next_cur.counterHalt = dat_i[timer_pkg::HALT_BIT];
          next_cur.wrapIrqEnable = dat_i[timer_pkg::IRQ_EN_BIT];
          clearWrap = !dat_i[timer_pkg::WRAP_FLAG_BIT];
        end
        timer_pkg::OFF_LIM_HIGH: begin
          next_cur.limitHigh = dat_i[7:0];
          next_cur.limitPending = 1'b1;
        end
        timer_pkg::OFF_LIM_LOW: begin
          next_cur.limitLow = lane0(cur.limitLow, sel_i, dat_i);
          next_cur.limitLive = {cur.limitHigh, dat_i[7:0]};
          next_cur.limitPending = 1'b0;
        end
        timer_pkg::OFF_IRQ_MASK: next_cur.irqMask = dat_i[timer_pkg::IRQ_WIDTH-1:0];
        default: ; // Counter bytes ignore writes
      endcase
    end
    if (rd) begin
      case (adr_i)
        timer_pkg::OFF_CTRL: next_cur.dat = {24'h000000, cur.wrapFlag, cur.wrapIrqEnable,
                                             cur.counterHalt, 1'b0, 1'b0, cur.divSelect};
        timer_pkg::OFF_CNT_HIGH: begin
          next_cur.dat = {24'h000000, count[15:8]};
          if (!cur.lowHeld) begin
            next_cur.lowHold = count[7:0];
            next_cur.lowHeld = 1'b1;
          end
        end
        timer_pkg::OFF_CNT_LOW: begin
          next_cur.dat = {24'h000000, cur.lowHeld ? cur.lowHold : count[7:0]};
          next_cur.lowHeld = 1'b0;
        end
        timer_pkg::OFF_LIM_HIGH: next_cur.dat = {24'h000000, cur.limitHigh};
        timer_pkg::OFF_LIM_LOW: next_cur.dat = {24'h000000, cur.limitLow};
        timer_pkg::OFF_IRQ_STATUS: begin
          next_cur.dat = {{(32-timer_pkg::IRQ_WIDTH){1'b0}}, cur.irqStatus};
          next_cur.irqStatus = '0;
        end
        timer_pkg::OFF_IRQ_MASK: next_cur.dat = {{(32-timer_pkg::IRQ_WIDTH){1'b0}},
                                                 cur.irqMask};
        default: next_cur.dat = 32'h00000000;
      endcase
    end
    // Setting wins over a clear in the same cycle
    if (clearWrap) next_cur.wrapFlag = 1'b0;
    if (setWrap) begin
      next_cur.wrapFlag = 1'b1;
      next_cur.irqStatus[timer_pkg::IRQ_WRAP_BIT] = 1'b1;
    end
    // Level interrupt from enabled flag or unmasked sticky status
    next_cur.irq = (next_cur.wrapFlag && next_cur.wrapIrqEnable) ||
                   |(next_cur.irqStatus & next_cur.irqMask);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.divSelect <= timer_pkg::DIV_RESET;
      cur.counterHalt <= timer_pkg::HALT_RESET;
      cur.limitHigh <= timer_pkg::LIMIT_BYTE_RESET;
      cur.limitLow <= timer_pkg::LIMIT_BYTE_RESET;
      cur.limitLive <= {timer_pkg::LIMIT_BYTE_RESET, timer_pkg::LIMIT_BYTE_RESET};
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops
  assign dat_o = cur.dat;
  assign ack_o = cur.ack;
  assign err_o = cur.err;
  assign irq = cur.irq;
endmodule : timer_unit

// *** test/timer_unit_chk.sv ***
/*
  Port checker for the prescaled modulo timer, bound into timer_unit.
  Assumes classic Wishbone on ref_clk and byte lane 0 for data.
*/
`timescale 1ns/1ps
module timer_unit_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // Interrupt
  input wire logic irq
);
  wire take = cyc_i & stb_i & ~ack_o & ~err_o;
  wire wr = ack_o & we_i & sel_i[0];
  wire rd = ack_o & ~we_i;
  wire mapped = (adr_i <= timer_pkg::OFF_IRQ_MASK) && (adr_i[1:0] == 2'h0);
  logic [7:0] ctl, limH, limL;
  logic msk, zero;
  // Shadows of what software wrote; zero tracks a counter held at zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl <= 8'h20;
      limH <= 8'hFF;
      limL <= 8'hFF;
      msk <= 1'b0;
      zero <= 1'b1;
    end else if (wr) begin
      if (adr_i == timer_pkg::OFF_CTRL) begin
        ctl <= dat_i[7:0] & 8'h67;
        zero <= dat_i[5] & (dat_i[4] | zero);
      end
      if (adr_i == timer_pkg::OFF_LIM_HIGH) limH <= dat_i[7:0];
      if (adr_i == timer_pkg::OFF_LIM_LOW) limL <= dat_i[7:0];
      if (adr_i == timer_pkg::OFF_IRQ_MASK) msk <= dat_i[0];
    end
  end
  answer_next_a: assert property (@(posedge ref_clk) disable iff (rst)
    take && mapped |=> ack_o && !err_o) else $error("mapped request not acked");
  unmapped_err_a: assert property (@(posedge ref_clk) disable iff (rst)
    take && !mapped |=> err_o && !ack_o) else $error("unmapped request not refused");
  ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    ack_o |=> !ack_o) else $error("ack longer than one cycle");
  ctrl_readback_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd && adr_i == timer_pkg::OFF_CTRL |-> (dat_o[6:0] & 7'h67) == ctl[6:0])
    else $error("control readback wrong");
  restart_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd && adr_i == timer_pkg::OFF_CTRL |-> !dat_o[4]) else $error("restart bit read as one");
  limit_readback_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd && adr_i == timer_pkg::OFF_LIM_HIGH |-> dat_o[7:0] == limH
  ) else $error("limit high readback wrong");
  limit_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd && adr_i == timer_pkg::OFF_LIM_LOW |-> dat_o[7:0] == limL) else $error("limit low wrong");
  irq_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    !ctl[6] && !msk && !wr |-> !irq) else $error("irq while disabled");
  held_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd && adr_i == timer_pkg::OFF_CNT_HIGH && zero |-> dat_o[7:0] == 8'h00)
    else $error("halted counter not zero");
endmodule : timer_unit_chk

bind timer_unit timer_unit_chk i_chk (.ref_clk(ref_clk), .rst(rst), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .irq(irq));

// *** test/timer_unit_tb_top.sv ***
/*
  Register-level testbench for the prescaled modulo timer.
  Assumes the design answers each Wishbone request within a few cycles.
*/
`timescale 1ns/1ps
module timer_unit_tb_top;
  logic ref_clk = 1'b0;
  logic rst, cyc_i, stb_i, we_i, ack_o, err_o, irq, e;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [15:0] x;
  int bad_count, check_count, n, c, ex;
  timer_unit i_dut (.ref_clk(ref_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .irq(irq));
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  task wrap_up;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [15:0] got, input int lo, input int hi);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      bad_count++;
      $display("[ERR] %s expected %0d..%0d seen %h", nm, lo, hi, got);
    end
  endtask : chk
  // One classic cycle; request held until ack or err is sampled
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, 24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("[ERR] bus answer expected 1 seen 0");
      wrap_up();
    end
    q = dat_o;
    e = err_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
    @(posedge ref_clk);
  endtask : wb
  task rdc(input string nm, input logic [7:0] a, input int lo, input int hi);
    wb(1'b0, a, 8'h00);
    chk(nm, q[15:0], lo, hi);
  endtask : rdc
  task cnt;
    wb(1'b0, timer_pkg::OFF_CNT_HIGH, 8'h00);
    x[15:8] = q[7:0];
    wb(1'b0, timer_pkg::OFF_CNT_LOW, 8'h00);
    x[7:0] = q[7:0];
  endtask : cnt
  // Main sequence
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, bad_count, check_count} = '0;
    rst = 1'b1;
    sel_i = 4'h1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rdc("ctrl reset", timer_pkg::OFF_CTRL, 8'h20, 8'h20);
    rdc("lim high reset", timer_pkg::OFF_LIM_HIGH, 8'hFF, 8'hFF);
    rdc("lim low reset", timer_pkg::OFF_LIM_LOW, 8'hFF, 8'hFF);
    wb(1'b1, timer_pkg::OFF_CNT_HIGH, 8'h55);
    cnt();
    chk("count reset", x, 0, 0);
    wb(1'b0, 8'h1C, 8'h00);
    chk("unmapped err", {15'h0, e}, 1, 1);
    for (c = 0; c < 8; c++) begin
      wb(1'b1, timer_pkg::OFF_CTRL, {5'h02, c[2:0]});
      repeat (512) @(posedge ref_clk);
      wb(1'b1, timer_pkg::OFF_CTRL, {5'h04, c[2:0]});
      ex = (c == 7) ? 0 : (512 >> c);
      cnt();
      chk("divided count", x, ex, (c == 7) ? 0 : ex + 4);
    end
    // Low byte capture survives a second high read
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h10);
    repeat (40) @(posedge ref_clk);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h20);
    cnt();
    wb(1'b0, timer_pkg::OFF_CNT_HIGH, 8'h00);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h00);
    repeat (20) @(posedge ref_clk);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h20);
    wb(1'b0, timer_pkg::OFF_CNT_HIGH, 8'h00);
    rdc("latched low", timer_pkg::OFF_CNT_LOW, x[7:0], x[7:0]);
    rdc("released low", timer_pkg::OFF_CNT_LOW, x[7:0] + 20, x[7:0] + 30);
    // Wrap at a small limit, then status and enable paths
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h30);
    cnt();
    chk("restart halted", x, 0, 0);
    wb(1'b1, timer_pkg::OFF_LIM_HIGH, 8'h00);
    wb(1'b1, timer_pkg::OFF_LIM_LOW, 8'h05);
    wb(1'b1, timer_pkg::OFF_IRQ_MASK, 8'h01);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h10);
    for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge ref_clk);
    chk("wrap irq", {15'h0, irq}, 1, 1);
    if (irq !== 1'b1) wrap_up();
    wb(1'b1, timer_pkg::OFF_CTRL, 8'hA0);
    cnt();
    chk("within limit", x, 0, 5);
    rdc("ctrl flag", timer_pkg::OFF_CTRL, 8'hA0, 8'hA0);
    rdc("status", timer_pkg::OFF_IRQ_STATUS, 1, 1);
    rdc("status cleared", timer_pkg::OFF_IRQ_STATUS, 0, 0);
    chk("irq off", {15'h0, irq}, 0, 0);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'hE0);
    @(posedge ref_clk);
    chk("irq enabled", {15'h0, irq}, 1, 1);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h20);
    @(posedge ref_clk);
    chk("irq flag cleared", {15'h0, irq}, 0, 0);
    // Half-written limit keeps the flag off
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h30);
    wb(1'b1, timer_pkg::OFF_LIM_HIGH, 8'h00);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h00);
    repeat (60) @(posedge ref_clk);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h20);
    rdc("flag held off", timer_pkg::OFF_CTRL, 8'h20, 8'h20);
    rdc("status held off", timer_pkg::OFF_IRQ_STATUS, 0, 0);
    wb(1'b1, timer_pkg::OFF_LIM_LOW, 8'h05);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'h00);
    repeat (20) @(posedge ref_clk);
    wb(1'b1, timer_pkg::OFF_CTRL, 8'hA0);
    rdc("flag after low", timer_pkg::OFF_CTRL, 8'hA0, 8'hA0);
    wrap_up();
  end
endmodule : timer_unit_tb_top
